// *** logic/lbc_cfg.svh ***
// constants for the tributary loopback and alarm control block
// assumes a single 100 MHz clock and a byte-wide register port
// Contract
// - code select 00 or 11 picks the standard C-bit request pattern
// - code select 01 and 10 pick two alternative legacy C-bit patterns
// - code select clears to zero on hardware and on software reset
// - rx alarm bit n forces demultiplexed tributary n to all ones
// - rx alarm acts after the loopback tap, so both can coexist
// - tx alarm bit n forces tributary n entering the line to all ones
// - tx alarm acts before loop select; looped slots carry looped data
// - loop bit n sends received tributary n into transmitted slot n
// - demultiplexed outputs keep received payload while looped back
// - request insert bit n codes the selected request into tx C-bits
// - detected bit n reflects the filtered recognition of request n
// - detection and removal each need five consecutive M-frames
// - changed bit n latches high on every change of detected bit n
// - with irq enable set, any changed bit drives irq low
// - reading the changed register clears it and releases irq
// - one code select governs inserted and expected pattern alike
// - with irq enable clear the irq stays inactive; enable resets 0
// - C-bit parity mode stops detection and insertion, sends C-bits 1
`ifndef LBC_CFG_SVH
`define LBC_CFG_SVH

`define LBC_ADDR_CONFIG 8'h28
`define LBC_ADDR_RX_ALARM 8'h29
`define LBC_ADDR_TX_ALARM 8'h2A
`define LBC_ADDR_LOOP 8'h2B
`define LBC_ADDR_REQ_INS 8'h2C
`define LBC_ADDR_REQ_DET 8'h2D
`define LBC_ADDR_REQ_CHG 8'h2E

`define LBC_CFG_IRQ_EN 0
`define LBC_CFG_CPAR 1
`define LBC_CFG_CODE_LO 2
`define LBC_CFG_CODE_HI 3

`define LBC_RESET_TRIB 7'h00
`define LBC_RESET_CODE 2'h0
`define LBC_READ_ZERO 8'h00
`define LBC_PAD1 1'h0
`define LBC_PAD4 4'h0

`define LBC_CODE_STD_A 2'h0
`define LBC_CODE_ALT_A 2'h1
`define LBC_CODE_ALT_B 2'h2
`define LBC_CODE_STD_B 2'h3

`define LBC_CBIT_NONE 2'h0
`define LBC_CBIT_1 2'h1
`define LBC_CBIT_2 2'h2
`define LBC_CBIT_3 2'h3

`define LBC_TRIB_NONE 3'h0
`define LBC_PERSIST_FRAMES 3'h5
`define LBC_CNT_ZERO 3'h0
`define LBC_CNT_ONE 3'h1

`define LBC_TRIB_FIRST 1
`define LBC_TRIB_LAST 7
`define LBC_TRIB_MSB 6

`endif

// *** logic/lbc_pkg.sv ***
// types and pattern helpers for the tributary loopback control block
// assumes lbc_cfg.svh is on the include path
`include "lbc_cfg.svh"

package lbc_pkg;

	typedef logic [2:0] lbc_trib_t;
	typedef logic [1:0] lbc_cbit_t;
	typedef logic [7:1] lbc_vec_t;

	// one received line bit, tagged by the framer
	typedef struct packed {
		logic valid;
		logic line_rx_data;
		lbc_trib_t trib;
		lbc_cbit_t cbit;
	} lbc_rx_s;

	// one bit from the mux stage, tagged the same way
	typedef struct packed {
		logic valid;
		logic data;
		lbc_trib_t trib;
		lbc_cbit_t cbit;
	} lbc_tx_s;

	typedef struct packed {
		logic valid;
		logic data;
		lbc_trib_t trib;
	} lbc_dmx_s;

	typedef struct packed {
		logic valid;
		logic line_tx_data;
	} lbc_line_s;

	function automatic logic lbc_pick(lbc_vec_t v, lbc_trib_t t);
		logic r;
		r = 1'b0;
		if (t != `LBC_TRIB_NONE) begin
			r = v[t];
		end
		return r;
	endfunction

	// request recognised in one C-bit triple
	function automatic logic lbc_match(lbc_cbit_t code, logic c1,
			logic c2, logic c3);
		logic r;
		r = 1'b0;
		case (code)
			`LBC_CODE_ALT_A: r = (c1 == c3) && (c1 != c2);
			`LBC_CODE_ALT_B: r = (c2 == c3) && (c1 != c2);
			default: r = (c1 == c2) && (c1 != c3);
		endcase
		return r;
	endfunction

	// C2/C3 value to send, C1 kept from the stuffing logic
	function automatic logic lbc_encode(lbc_cbit_t code, lbc_cbit_t idx,
			logic c1);
		logic r;
		r = c1;
		case (code)
			`LBC_CODE_ALT_A: r = (idx == `LBC_CBIT_2) ? !c1 : c1;
			`LBC_CODE_ALT_B: r = !c1;
			default: r = (idx == `LBC_CBIT_3) ? !c1 : c1;
		endcase
		return r;
	endfunction

endpackage

// *** logic/lbc_loop_ctrl.sv ***
// tributary loopback, alarm insertion and C-bit request control
// assumes framer tags on the same clock; rx and tx slots run in step
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`include "lbc_cfg.svh"

module lbc_loop_ctrl
	import lbc_pkg::*;
(
	// clock and resets
	input wire logic CLOCK_IN,
	input wire logic RESET_IN,
	input wire logic SW_RESET_IN,
	// register port
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic [7:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	output logic [7:0] REG_RDATA_OUT,
	// received line and demultiplexed tributaries
	input wire lbc_rx_s RX_LINE_IN,
	output lbc_dmx_s DMX_OUT,
	// mux stage bits and transmitted line
	input wire lbc_tx_s TX_TRIB_IN,
	output lbc_line_s TX_LINE_OUT,
	// interrupt
	output logic IRQ_N_OUT
);

	lbc_vec_t rx_alarm_ff;
	lbc_vec_t tx_alarm_ff;
	lbc_vec_t loop_ff;
	lbc_vec_t req_ins_ff;
	lbc_vec_t det_ff;
	lbc_vec_t nxt_det;
	lbc_vec_t chg_ff;
	lbc_vec_t seen_ff;
	lbc_vec_t loop_hold_ff;
	lbc_cbit_t loop_code_select_ff;
	logic cparity_mode_enable_ff;
	logic mux_irq_enable_ff;
	logic [7:0] rdata_ff;
	logic irq_n_ff;
	lbc_dmx_s dmx_ff;
	lbc_line_s tx_ff;
	logic rx_c1_ff;
	logic rx_c2_ff;
	logic tx_c1_ff;
	logic rx_pay;
	logic tx_pay;
	logic rx_hit;
	logic mframe_end;
	logic chg_read;
	logic any_det_change;
	logic tx_loop_bit;
	logic tx_alarm_bit;
	logic tx_next;

	assign REG_RDATA_OUT = rdata_ff;
	assign IRQ_N_OUT = irq_n_ff;
	assign DMX_OUT = dmx_ff;
	assign TX_LINE_OUT = tx_ff;

	// M-frame end travels as the C-bit slot with no tributary
	assign mframe_end = RX_LINE_IN.valid &&
		RX_LINE_IN.trib == `LBC_TRIB_NONE &&
		RX_LINE_IN.cbit == `LBC_CBIT_3;
	assign rx_pay = RX_LINE_IN.valid && RX_LINE_IN.cbit == `LBC_CBIT_NONE &&
		RX_LINE_IN.trib != `LBC_TRIB_NONE;
	assign tx_pay = TX_TRIB_IN.valid && TX_TRIB_IN.cbit == `LBC_CBIT_NONE &&
		TX_TRIB_IN.trib != `LBC_TRIB_NONE;
	assign chg_read = REG_RD_IN && REG_ADDR_IN == `LBC_ADDR_REQ_CHG;
	assign any_det_change = |(nxt_det ^ det_ff);
	assign tx_loop_bit = lbc_pick(loop_hold_ff, TX_TRIB_IN.trib);
	assign tx_alarm_bit = lbc_pick(tx_alarm_ff, TX_TRIB_IN.trib);
	// one code select serves both directions
	assign rx_hit = RX_LINE_IN.valid && RX_LINE_IN.cbit == `LBC_CBIT_3 &&
		RX_LINE_IN.trib != `LBC_TRIB_NONE && !cparity_mode_enable_ff &&
		lbc_match(loop_code_select_ff, rx_c1_ff, rx_c2_ff,
		RX_LINE_IN.line_rx_data);

	// configuration register
	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			loop_code_select_ff <= `LBC_RESET_CODE;
			cparity_mode_enable_ff <= 1'b0;
			mux_irq_enable_ff <= 1'b0;
		end else if (SW_RESET_IN) begin
			loop_code_select_ff <= `LBC_RESET_CODE;
			cparity_mode_enable_ff <= 1'b0;
			mux_irq_enable_ff <= 1'b0;
		end else if (REG_WR_IN && REG_ADDR_IN == `LBC_ADDR_CONFIG) begin
			loop_code_select_ff <=
				REG_WDATA_IN[`LBC_CFG_CODE_HI:`LBC_CFG_CODE_LO];
			cparity_mode_enable_ff <= REG_WDATA_IN[`LBC_CFG_CPAR];
			mux_irq_enable_ff <= REG_WDATA_IN[`LBC_CFG_IRQ_EN];
		end
	end

	// per-tributary control vectors; bit 7 of each byte is unused
	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			rx_alarm_ff <= `LBC_RESET_TRIB;
			tx_alarm_ff <= `LBC_RESET_TRIB;
			loop_ff <= `LBC_RESET_TRIB;
			req_ins_ff <= `LBC_RESET_TRIB;
		end else if (SW_RESET_IN) begin
			rx_alarm_ff <= `LBC_RESET_TRIB;
			tx_alarm_ff <= `LBC_RESET_TRIB;
			loop_ff <= `LBC_RESET_TRIB;
			req_ins_ff <= `LBC_RESET_TRIB;
		end else if (REG_WR_IN) begin
			case (REG_ADDR_IN)
				`LBC_ADDR_RX_ALARM:
					rx_alarm_ff <= REG_WDATA_IN[`LBC_TRIB_MSB:0];
				`LBC_ADDR_TX_ALARM:
					tx_alarm_ff <= REG_WDATA_IN[`LBC_TRIB_MSB:0];
				`LBC_ADDR_LOOP: loop_ff <= REG_WDATA_IN[`LBC_TRIB_MSB:0];
				`LBC_ADDR_REQ_INS:
					req_ins_ff <= REG_WDATA_IN[`LBC_TRIB_MSB:0];
				default: ;
			endcase
		end
	end

	// read data, valid only in the cycle after the strobe
	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			rdata_ff <= `LBC_READ_ZERO;
		end else if (REG_RD_IN) begin
			case (REG_ADDR_IN)
				`LBC_ADDR_CONFIG: rdata_ff <= {`LBC_PAD4, loop_code_select_ff,
					cparity_mode_enable_ff, mux_irq_enable_ff};
				`LBC_ADDR_RX_ALARM: rdata_ff <= {`LBC_PAD1, rx_alarm_ff};
				`LBC_ADDR_TX_ALARM: rdata_ff <= {`LBC_PAD1, tx_alarm_ff};
				`LBC_ADDR_LOOP: rdata_ff <= {`LBC_PAD1, loop_ff};
				`LBC_ADDR_REQ_INS: rdata_ff <= {`LBC_PAD1, req_ins_ff};
				`LBC_ADDR_REQ_DET: rdata_ff <= {`LBC_PAD1, det_ff};
				`LBC_ADDR_REQ_CHG: rdata_ff <= {`LBC_PAD1, chg_ff};
				default: rdata_ff <= `LBC_READ_ZERO;
			endcase
		end else begin
			rdata_ff <= `LBC_READ_ZERO;
		end
	end

	// receive C-bit capture; C3 completes the triple
	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			rx_c1_ff <= 1'b0;
			rx_c2_ff <= 1'b0;
		end else if (RX_LINE_IN.valid && RX_LINE_IN.cbit == `LBC_CBIT_1) begin
			rx_c1_ff <= RX_LINE_IN.line_rx_data;
		end else if (RX_LINE_IN.valid && RX_LINE_IN.cbit == `LBC_CBIT_2) begin
			rx_c2_ff <= RX_LINE_IN.line_rx_data;
		end
	end

	// per-M-frame sighting, restarted at each frame end
	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			seen_ff <= `LBC_RESET_TRIB;
		end else if (mframe_end) begin
			seen_ff <= `LBC_RESET_TRIB;
		end else if (rx_hit) begin
			seen_ff[RX_LINE_IN.trib] <= 1'b1;
		end
	end

	// persistence filter, one counter per tributary
	logic [2:0] cnt_ff [`LBC_TRIB_LAST:`LBC_TRIB_FIRST];
	logic [2:0] nxt_cnt [`LBC_TRIB_LAST:`LBC_TRIB_FIRST];

	always_comb begin
		for (int i = `LBC_TRIB_FIRST; i <= `LBC_TRIB_LAST; i++) begin
			nxt_cnt[i] = cnt_ff[i];
			nxt_det[i] = det_ff[i];
			if (cparity_mode_enable_ff) begin
				nxt_cnt[i] = `LBC_CNT_ZERO;
				nxt_det[i] = 1'b0;
			end else if (mframe_end) begin
				if (seen_ff[i] == det_ff[i]) begin
					nxt_cnt[i] = `LBC_CNT_ZERO;
				end else if (cnt_ff[i] == `LBC_PERSIST_FRAMES -
						`LBC_CNT_ONE) begin
					nxt_cnt[i] = `LBC_CNT_ZERO;
					nxt_det[i] = seen_ff[i];
				end else begin
					nxt_cnt[i] = cnt_ff[i] + `LBC_CNT_ONE;
				end
			end
		end
	end

	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			for (int i = `LBC_TRIB_FIRST; i <= `LBC_TRIB_LAST; i++) begin
				cnt_ff[i] <= `LBC_CNT_ZERO;
			end
			det_ff <= `LBC_RESET_TRIB;
		end else begin
			for (int i = `LBC_TRIB_FIRST; i <= `LBC_TRIB_LAST; i++) begin
				cnt_ff[i] <= nxt_cnt[i];
			end
			det_ff <= nxt_det;
		end
	end

	// a change in the read cycle survives the clear
	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			chg_ff <= `LBC_RESET_TRIB;
		end else begin
			for (int i = `LBC_TRIB_FIRST; i <= `LBC_TRIB_LAST; i++) begin
				if (nxt_det[i] != det_ff[i]) begin
					chg_ff[i] <= 1'b1;
				end else if (chg_read) begin
					chg_ff[i] <= 1'b0;
				end
			end
		end
	end

	genvar gi;
	generate
		for (gi = `LBC_TRIB_FIRST; gi <= `LBC_TRIB_LAST; gi++)
				begin : g_trib
			chk_det_persist: assert property (
				@(posedge CLOCK_IN) disable iff (RESET_IN)
				mframe_end && !cparity_mode_enable_ff &&
				seen_ff[gi] != det_ff[gi] &&
				cnt_ff[gi] == `LBC_PERSIST_FRAMES - `LBC_CNT_ONE
				|=> det_ff[gi] != $past(det_ff[gi]))
				else $error("detection did not toggle after five frames");

			chk_det_hold: assert property (
				@(posedge CLOCK_IN) disable iff (RESET_IN)
				!mframe_end && !cparity_mode_enable_ff |=> $stable(det_ff[gi]))
				else $error("detection moved outside an M-frame end");

			chk_chg_latch: assert property (
				@(posedge CLOCK_IN) disable iff (RESET_IN)
				$changed(det_ff[gi]) |-> chg_ff[gi])
				else $error("detection change not latched");
		end
	endgenerate

	// gated OR of changes, held until the clearing read
	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			irq_n_ff <= 1'b1;
		end else begin
			irq_n_ff <= !(mux_irq_enable_ff && |chg_ff);
		end
	end

	// loopback tap sits before receive alarm insertion
	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			loop_hold_ff <= `LBC_RESET_TRIB;
		end else if (rx_pay) begin
			loop_hold_ff[RX_LINE_IN.trib] <= RX_LINE_IN.line_rx_data;
		end
	end

	// demultiplexed side: payload unchanged unless alarm forced
	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			dmx_ff <= '0;
		end else begin
			dmx_ff.valid <= rx_pay;
			dmx_ff.trib <= RX_LINE_IN.trib;
			dmx_ff.data <= RX_LINE_IN.line_rx_data ||
				lbc_pick(rx_alarm_ff, RX_LINE_IN.trib);
		end
	end

	// transmit C1 from the stuffing logic anchors the pattern
	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			tx_c1_ff <= 1'b0;
		end else if (TX_TRIB_IN.valid && TX_TRIB_IN.cbit == `LBC_CBIT_1) begin
			tx_c1_ff <= TX_TRIB_IN.data;
		end
	end

	// alarm first, loop select after it, C-bit coding alongside
	always_comb begin
		tx_next = TX_TRIB_IN.data;
		if (tx_pay) begin
			tx_next = TX_TRIB_IN.data || tx_alarm_bit;
			if (lbc_pick(loop_ff, TX_TRIB_IN.trib)) begin
				tx_next = tx_loop_bit;
			end
		end else if (TX_TRIB_IN.cbit != `LBC_CBIT_NONE) begin
			if (cparity_mode_enable_ff) begin
				tx_next = 1'b1;
			end else if (lbc_pick(req_ins_ff, TX_TRIB_IN.trib) &&
					TX_TRIB_IN.cbit != `LBC_CBIT_1) begin
				tx_next = lbc_encode(loop_code_select_ff, TX_TRIB_IN.cbit,
					tx_c1_ff);
			end
		end
	end

	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			tx_ff <= '0;
		end else begin
			tx_ff.valid <= TX_TRIB_IN.valid;
			tx_ff.line_tx_data <= tx_next;
		end
	end

	chk_code_reset: assert property (
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		SW_RESET_IN |=> loop_code_select_ff == `LBC_RESET_CODE)
		else $error("code select survived software reset");

	chk_rx_alarm: assert property (
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		rx_pay && lbc_pick(rx_alarm_ff, RX_LINE_IN.trib)
		|=> dmx_ff.valid && dmx_ff.data)
		else $error("receive alarm not all ones");

	chk_rx_clean: assert property (
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		rx_pay && !lbc_pick(rx_alarm_ff, RX_LINE_IN.trib)
		|=> dmx_ff.data == $past(RX_LINE_IN.line_rx_data))
		else $error("demultiplexed payload altered");

	chk_tx_loop: assert property (
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		tx_pay && lbc_pick(loop_ff, TX_TRIB_IN.trib)
		|=> TX_LINE_OUT.line_tx_data == $past(tx_loop_bit))
		else $error("looped slot lost the received bit");

	chk_tx_alarm: assert property (
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		tx_pay && tx_alarm_bit && !lbc_pick(loop_ff, TX_TRIB_IN.trib)
		|=> TX_LINE_OUT.line_tx_data)
		else $error("transmit alarm not all ones");

	chk_tx_cpar: assert property (
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		TX_TRIB_IN.valid && TX_TRIB_IN.cbit != `LBC_CBIT_NONE &&
		cparity_mode_enable_ff |=> TX_LINE_OUT.line_tx_data)
		else $error("C-bit not one in parity mode");

	chk_tx_request: assert property (
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		TX_TRIB_IN.valid && TX_TRIB_IN.cbit == `LBC_CBIT_3 &&
		!cparity_mode_enable_ff && lbc_pick(req_ins_ff, TX_TRIB_IN.trib) &&
		loop_code_select_ff == `LBC_CODE_STD_A
		|=> TX_LINE_OUT.line_tx_data == !$past(tx_c1_ff))
		else $error("request C3 not inverted from C1");

	chk_chg_clear: assert property (
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		chg_read && !any_det_change |=> chg_ff == `LBC_RESET_TRIB ##1 irq_n_ff)
		else $error("changed register not cleared by read");

	chk_irq_mask: assert property (
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		!mux_irq_enable_ff |=> IRQ_N_OUT)
		else $error("irq active while disabled");

	chk_irq_on: assert property (
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		mux_irq_enable_ff && |chg_ff |=> !IRQ_N_OUT)
		else $error("irq not raised on latched change");

	// nothing latched means the line must stay released
	chk_irq_idle: assert property (
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		!(|chg_ff) |=> IRQ_N_OUT)
		else $error("irq active with no latched change");

	chk_det_cpar: assert property (
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		cparity_mode_enable_ff |=> det_ff == `LBC_RESET_TRIB)
		else $error("detection alive in parity mode");

	chk_dmx_idle: assert property (
		@(posedge CLOCK_IN) disable iff (RESET_IN)
		RX_LINE_IN.valid && !rx_pay |=> !dmx_ff.valid)
		else $error("C-bit slot shown as payload");

endmodule

// *** verif/lbc_far_end.sv ***
// far-end mux model: framed tributary bits with C-bit loop requests
// assumes the device takes one tagged line bit on every clock
`timescale 1ns/100ps

module lbc_far_end
	import lbc_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// scenario control; request and code latched once per M-frame, payload used live
	input wire lbc_vec_t req_in,
	input wire lbc_vec_t pay_in,
	input wire lbc_cbit_t code_in,
	// line toward the device
	output lbc_rx_s line_out
);
	logic [4:0] step_ff;
	lbc_vec_t req_ff;
	lbc_cbit_t code_ff;
	lbc_trib_t t;
	lbc_cbit_t k;
	logic rq;
	logic [3:0] v;

	// slot order: payload, C1, C2, C3 per subframe, then frame end
	always_comb begin
		t = step_ff[4:2] + 3'h1;
		k = step_ff[1:0];
		rq = req_ff[t];
		v[0] = pay_in[t];
		// idle C-bits all ones, so no code can match them
		v[1] = !(rq && code_ff == 2'h2);
		v[2] = !(rq && code_ff == 2'h1);
		v[3] = !(rq && code_ff[0] == code_ff[1]);
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			step_ff <= 5'h00;
			req_ff <= '0;
			code_ff <= 2'h0;
			line_out <= '0;
		end else if (step_ff == 5'h1c) begin
			// request state changes only on a frame boundary
			step_ff <= 5'h00;
			req_ff <= req_in;
			code_ff <= code_in;
			line_out <= '{1'b1, 1'b0, 3'h0, 2'h3};
		end else begin
			step_ff <= step_ff + 5'h01;
			line_out <= '{1'b1, v[k], t, k};
		end
	end
endmodule

// *** verif/tb_lbc_loop_ctrl.sv ***
// bench for the tributary loopback and alarm control block
// assumes the far-end model and the block share one 100 MHz clock
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
	err_total++; $display("MISMATCH %s expected %h seen %h", n, e, g); \
	end end

module tb_lbc_loop_ctrl
	import lbc_pkg::*;
;
	logic clk, rst, sw_rst, wr, rd, irq_n, irq_seen;
	logic [7:0] addr, wdata, rdata, sh_cfg;
	lbc_vec_t sh_rxa, sh_txa, sh_loop, sh_ins, m_req, m_pay;
	lbc_cbit_t m_code;
	lbc_rx_s rx;
	lbc_tx_s tx_in;
	lbc_dmx_s dmx;
	lbc_line_s tx_line;
	int err_total, checked, cycles;

	lbc_loop_ctrl dut_u (.CLOCK_IN(clk), .RESET_IN(rst),
		.SW_RESET_IN(sw_rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
		.REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
		.RX_LINE_IN(rx), .DMX_OUT(dmx), .TX_TRIB_IN(tx_in),
		.TX_LINE_OUT(tx_line), .IRQ_N_OUT(irq_n));
	lbc_far_end far_u (.clk_in(clk), .rst_in(rst), .req_in(m_req),
		.pay_in(m_pay), .code_in(m_code), .line_out(rx));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// mux stage: same slot tags as the received line, zero data
	always @(posedge clk) begin
		tx_in <= '{rx.valid, 1'b0, rx.trib, rx.cbit};
	end

	// about 3000 cycles are needed; this leaves ample margin
	always @(posedge clk) begin
		cycles++;
		if (cycles == 10000) begin
			err_total++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		case (a)
			8'h28: sh_cfg = d & 8'h0f;
			8'h29: sh_rxa = d[6:0];
			8'h2a: sh_txa = d[6:0];
			8'h2b: sh_loop = d[6:0];
			8'h2c: sh_ins = d[6:0];
			default: ;
		endcase
		@(posedge clk);
	endtask

	task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		irq_seen = irq_n;
		`CHK("register", e, rdata)
		@(posedge clk);
	endtask

	task automatic wait_fe(input int n);
		repeat (n) begin
			@(posedge clk);
			while (!(rx.valid && rx.trib == 3'h0)) begin
				@(posedge clk);
			end
		end
	endtask

	// expected line bit for one mux-stage slot, from the shadows
	function automatic logic exp_tx(lbc_tx_s s);
		if (s.trib == 3'h0) return 1'b0;
		if (s.cbit == 2'h0) begin
			return sh_loop[s.trib] ? m_pay[s.trib] : s.data | sh_txa[s.trib];
		end
		if (sh_cfg[1]) return 1'b1;
		if (!sh_ins[s.trib] || s.cbit == 2'h1) return s.data;
		if (s.cbit == 2'h2) return sh_cfg[2] ^ sh_cfg[3];
		return sh_cfg[3:2] != 2'h1;
	endfunction

	task automatic check_frame();
		lbc_rx_s r;
		lbc_tx_s s;
		logic et;
		logic [4:0] e5;
		r = '0;
		s = '0;
		et = 1'b0;
		repeat (30) begin
			@(posedge clk);
			#1;
			if (s.valid && s.trib != 3'h0) begin
				`CHK("line", {1'b1, et}, tx_line)
			end
			if (r.valid && r.cbit == 2'h0) begin
				e5 = {1'b1, r.line_rx_data | sh_rxa[r.trib], r.trib};
				`CHK("dmx", e5, dmx)
			end else if (r.valid) begin
				`CHK("dmx idle", 1'b0, dmx.valid)
			end
			r = rx;
			s = tx_in;
			et = exp_tx(s);
		end
		@(posedge clk);
	endtask

	// one request on one tributary: assert, then remove
	task automatic detect(input logic [1:0] dc, input logic [1:0] mc,
			input int n, input logic en, input logic par);
		logic [7:0] b;
		logic [7:0] e;
		b = 8'h01 << (n - 1);
		e = 8'h00;
		if ((dc == mc || (dc[0] == dc[1] && mc[0] == mc[1])) && !par) begin
			e = b;
		end
		wr_reg(8'h28, {4'h0, dc, par, en});
		wait_fe(1);
		m_code <= mc;
		m_req <= b[6:0];
		wait_fe(5);
		chk_reg(8'h2d, 8'h00);
		wait_fe(1);
		chk_reg(8'h2d, e);
		`CHK("irq", !(en && e != 8'h00), irq_seen)
		chk_reg(8'h2e, e);
		chk_reg(8'h2e, 8'h00);
		`CHK("irq after read", 1'b1, irq_seen)
		wait_fe(1);
		m_req <= '0;
		wait_fe(5);
		chk_reg(8'h2d, e);
		wait_fe(1);
		chk_reg(8'h2d, 8'h00);
		chk_reg(8'h2e, e);
	endtask

	initial begin
		rst = 1'b1;
		sw_rst = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		m_req = '0;
		m_pay = 7'h55;
		m_code = 2'h0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (logic [7:0] a = 8'h28; a < 8'h2f; a++) begin
			chk_reg(a, 8'h00);
		end
		chk_reg(8'h30, 8'h00);
		wr_reg(8'h29, 8'ha2);
		wr_reg(8'h2a, 8'hac);
		wr_reg(8'h2b, 8'ha5);
		wr_reg(8'h2c, 8'hc1);
		wr_reg(8'h2d, 8'h7f);
		chk_reg(8'h29, 8'h22);
		chk_reg(8'h2a, 8'h2c);
		chk_reg(8'h2b, 8'h25);
		chk_reg(8'h2c, 8'h41);
		chk_reg(8'h2d, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr_reg(8'h28, {4'h0, 2'(c), 2'h0});
			chk_reg(8'h28, {4'h0, 2'(c), 2'h0});
			check_frame();
		end
		wr_reg(8'h28, 8'hfe);
		chk_reg(8'h28, 8'h0e);
		check_frame();
		sw_rst <= 1'b1;
		@(posedge clk);
		sw_rst <= 1'b0;
		@(posedge clk);
		for (logic [7:0] a = 8'h28; a < 8'h2d; a++) begin
			chk_reg(a, 8'h00);
		end
		for (int c = 0; c < 4; c++) begin
			detect(2'(c), 2'(c), c + 1, c != 3, 1'b0);
		end
		detect(2'h0, 2'h1, 5, 1'b1, 1'b0);
		detect(2'h0, 2'h0, 6, 1'b1, 1'b1);
		print_verdict();
	end
endmodule
